// >>> pkg/post_clear_regs.vh
// register map and field layout of the posted-interrupt unit
// assumes a wishbone bus with 32-bit words, one register per aligned word
`ifndef POST_CLEAR_REGS_VH
`define POST_CLEAR_REGS_VH

// ****************************************************************
// word indices (byte address is four times the index)
// ****************************************************************
`define IDX_POST_CLEAR 8'hda
`define IDX_SOURCE_MASK 8'he0
`define IDX_SW_CONTROL 8'he1
`define IDX_VECTOR 8'he2
`define IDX_IRQ_STATUS 8'hf0
`define IDX_IRQ_ENABLE 8'hf1
`define IDX_IRQ_CLEAR 8'hf2
`define IDX_GLOBAL_EN 8'hf3

// ****************************************************************
// fields and reset values
// ****************************************************************
`define NUM_SOURCES 8
`define SW_POST_EN_BIT 0
`define RESET_BYTE 8'h00
`define VEC_NONE 8'h00
`define VEC_BASE 8'h04
`define VEC_STEP 8'h04
`define STAT_POSTED 0
`define STAT_SWPOST 1
`define STAT_TAKEN 2
`define STAT_WIDTH 3

`endif

// >>> logic/priority_vector.v
// priority encoder of the pending sources into a vector
// assumes pending bits come from logic on the same clock
`timescale 1ns/1ps
`include "post_clear_regs.vh"
module priority_vector (
  // pending sources
  input wire [7:0] i_pending,
  // encoded result
  output reg [7:0] o_vector,
  output reg o_any
);
  integer k;
  // lowest bit index wins, as the supply monitor is the most urgent source
  always @* begin
    o_vector = `VEC_NONE;
    o_any = 1'b0;
    for (k = `NUM_SOURCES - 1; k >= 0; k = k - 1) begin
      if (i_pending[k]) begin
        o_vector = `VEC_BASE + (k[7:0] * `VEC_STEP);
        o_any = 1'b1;
      end
    end
  end
endmodule

// >>> logic/interrupt_post_clear_unit.v
// posted-interrupt flags, mask, vector and wishbone register file
// assumes event inputs are one-cycle pulses on i_clk; take ack likewise
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`include "post_clear_regs.vh"
module interrupt_post_clear_unit (
  // clock, reset, enable
  input wire i_clk,
  input wire i_rst,
  input wire i_ce,
  // wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [9:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // source events, bit order as the clear register
  input wire [7:0] i_src_event,
  // core side
  input wire i_take_ack,
  output reg o_core_req,
  output reg [7:0] o_core_vector,
  // block interrupt
  output reg o_irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  reg [7:0] posted_reg;
  reg [7:0] posted_next;
  reg [7:0] mask_reg;
  reg sw_post_en_reg;
  reg global_en_reg;
  reg [`STAT_WIDTH-1:0] status_reg;
  reg [`STAT_WIDTH-1:0] status_next;
  reg [`STAT_WIDTH-1:0] enable_reg;
  reg [7:0] taken_reg;
  reg [31:0] rdata;
  wire [7:0] pending;
  wire [7:0] vector;
  wire any_pending;
  wire [7:0] idx;
  wire access;
  wire wr;
  wire wr0;
  wire wr_clear;
  wire [7:0] wbyte;
  wire [7:0] hw_set;
  wire [7:0] sw_set;
  wire [7:0] sw_clr;
  wire [7:0] take_clr;
  wire [7:0] lowest_pending;
  wire wr_mask;
  wire wr_sw_ctl;
  wire wr_irq_en;
  wire wr_global;
  wire take_now;
  wire core_req_next;

  assign idx = i_wb_adr[9:2];
  assign access = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = access & i_wb_we;
  assign wr0 = wr & i_wb_sel[0];
  assign wbyte = i_wb_dat[7:0];
  // only the clear register, never the vector register, edits the flags
  assign wr_clear = wr0 & (idx == `IDX_POST_CLEAR);

  // ****************************************************************
  // posted flags
  // ****************************************************************
  // the mask does not enter the set path
  assign hw_set = i_src_event;
  assign sw_set = (wr_clear & sw_post_en_reg) ? wbyte : `RESET_BYTE;
  assign sw_clr = (wr_clear & ~sw_post_en_reg) ? ~wbyte : `RESET_BYTE;
  assign take_clr = (o_core_req & i_take_ack) ? taken_reg : `RESET_BYTE;

  genvar g;
  generate
    for (g = 0; g < `NUM_SOURCES; g = g + 1) begin : gen_flag
      // set wins over any clear in the same cycle
      always @* begin
        posted_next[g] = posted_reg[g];
        if (sw_clr[g] | take_clr[g]) begin
          posted_next[g] = 1'b0;
        end
        if (hw_set[g] | sw_set[g]) begin
          posted_next[g] = 1'b1;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // pending, priority and core request
  // ****************************************************************
  assign pending = posted_reg & mask_reg;
  priority_vector u_prio (
    .i_pending(pending),
    .o_vector(vector),
    .o_any(any_pending)
  );

  // ****************************************************************
  // block status events
  // ****************************************************************
  always @* begin
    status_next = status_reg;
    if (wr0 && idx == `IDX_IRQ_CLEAR) begin
      status_next = status_reg & ~wbyte[`STAT_WIDTH-1:0];
    end
    if (|hw_set) begin
      status_next[`STAT_POSTED] = 1'b1;
    end
    if (|sw_set) begin
      status_next[`STAT_SWPOST] = 1'b1;
    end
    if (o_core_req & i_take_ack) begin
      status_next[`STAT_TAKEN] = 1'b1;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always @* begin
    rdata = 32'h0000_0000;
    case (idx)
      `IDX_POST_CLEAR: rdata[7:0] = posted_reg;
      `IDX_SOURCE_MASK: rdata[7:0] = mask_reg;
      `IDX_SW_CONTROL: rdata[`SW_POST_EN_BIT] = sw_post_en_reg;
      `IDX_VECTOR: rdata[7:0] = vector;
      `IDX_IRQ_STATUS: rdata[`STAT_WIDTH-1:0] = status_reg;
      `IDX_IRQ_ENABLE: rdata[`STAT_WIDTH-1:0] = enable_reg;
      `IDX_GLOBAL_EN: rdata[0] = global_en_reg;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // write strobes and core side next values
  // ****************************************************************
  assign wr_mask = wr0 & (idx == `IDX_SOURCE_MASK);
  assign wr_sw_ctl = wr0 & (idx == `IDX_SW_CONTROL);
  assign wr_irq_en = wr0 & (idx == `IDX_IRQ_ENABLE);
  assign wr_global = wr0 & (idx == `IDX_GLOBAL_EN);
  assign take_now = o_core_req & i_take_ack;
  // only the lowest pending index is offered, so only it is taken
  assign lowest_pending = pending & ~(pending - 8'h01);
  // drop the request for one cycle after a take so it is not taken twice
  assign core_req_next = any_pending & global_en_reg & ~take_now;

  // ****************************************************************
  // posted flag registers
  // ****************************************************************
  generate
    for (g = 0; g < `NUM_SOURCES; g = g + 1) begin : gen_flag_reg
      always @(posedge i_clk) begin
        if (i_rst) begin
          posted_reg[g] <= 1'b0;
        end else if (i_ce) begin
          posted_reg[g] <= posted_next[g];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // software post enable
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      sw_post_en_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_sw_ctl) begin
        sw_post_en_reg <= wbyte[`SW_POST_EN_BIT];
      end
    end
  end

  // ****************************************************************
  // source mask
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      mask_reg <= `RESET_BYTE;
    end else if (i_ce) begin
      if (wr_mask) begin
        // all eight bits of the written byte are stored as the mask
        mask_reg <= wbyte;
      end
    end
  end

  // ****************************************************************
  // global enable
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      global_en_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_global) begin
        global_en_reg <= wbyte[0];
      end
    end
  end

  // ****************************************************************
  // block status
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      status_reg <= {`STAT_WIDTH{1'b0}};
    end else if (i_ce) begin
      status_reg <= status_next;
    end
  end

  // ****************************************************************
  // block interrupt enable
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      enable_reg <= {`STAT_WIDTH{1'b0}};
    end else if (i_ce) begin
      if (wr_irq_en) begin
        enable_reg <= wbyte[`STAT_WIDTH-1:0];
      end
    end
  end

  // ****************************************************************
  // source offered to the core
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      taken_reg <= `RESET_BYTE;
    end else if (i_ce) begin
      // matches the vector registered in the same cycle
      taken_reg <= any_pending ? lowest_pending : `RESET_BYTE;
    end
  end

  // ****************************************************************
  // bus acknowledge
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
    end else if (i_ce) begin
      // access excludes a held request, so ack is a single pulse
      o_wb_ack <= access;
    end
  end

  // ****************************************************************
  // bus read data
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (i_ce) begin
      o_wb_dat <= access ? rdata : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // core request
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_core_req <= 1'b0;
    end else if (i_ce) begin
      o_core_req <= core_req_next;
    end
  end

  // ****************************************************************
  // core vector
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_core_vector <= `VEC_NONE;
    end else if (i_ce) begin
      o_core_vector <= vector;
    end
  end

  // ****************************************************************
  // block interrupt
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      // next status is used so the level follows a clear without delay
      o_irq <= |(status_next & enable_reg);
    end
  end

endmodule

// >>> testbench/core_model.sv
// core model: takes an offered interrupt when allowed
// assumes the unit's clock and sync reset
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // control and unit side
  input wire i_allow,
  input wire i_core_req,
  output reg o_take_ack
);
  always @(posedge i_clk) begin
    o_take_ack <= !i_rst && i_allow && i_core_req && !o_take_ack;
  end
endmodule

// >>> testbench/post_clear_assertions.sv
// checker on the unit's ports
// assumes i_ce held high
`timescale 1ns/1ps
module post_clear_assertions (
  // watched ports
  input wire i_clk, i_rst, i_wb_cyc, i_wb_stb, o_wb_ack, o_core_req, o_irq,
  input wire [31:0] o_wb_dat,
  input wire [7:0] o_core_vector
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ack_one_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  ack_next_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack late");
  ack_cause_a: assert property ($rose(o_wb_ack) |-> $past(i_wb_cyc && i_wb_stb))
    else $error("stray ack");
  data_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("data");
  data_upper_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("upper bits");
  req_vector_a: assert property (o_core_req |-> o_core_vector != 8'h00)
    else $error("no vector");
  vector_form_a: assert property (o_core_vector[1:0] == 2'h0 && o_core_vector <= 8'h20)
    else $error("bad vector");
  reset_quiet_a: assert property (disable iff (1'b0) i_rst |=> !o_wb_ack && !o_core_req && !o_irq)
    else $error("busy after reset");
endmodule
bind interrupt_post_clear_unit post_clear_assertions chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_core_req(o_core_req),
  .o_irq(o_irq), .o_wb_dat(o_wb_dat), .o_core_vector(o_core_vector));

// >>> testbench/tb_top.sv
// bench: wishbone tasks and register tests
// assumes core_model as core, checker bound
`timescale 1ns/1ps
`include "post_clear_regs.vh"
module tb_top;
  localparam [7:0] clr = `IDX_POST_CLEAR;
  localparam [7:0] nul = 8'h10;
  reg i_clk, i_rst, cyc, stb, we, allow;
  reg [9:0] adr;
  reg [31:0] wd;
  reg [7:0] ev, rd;
  wire [31:0] dat;
  wire [7:0] vec;
  wire ack, req, take, irq;
  integer fails, cmp_count;
  interrupt_post_clear_unit dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wd),
    .o_wb_dat(dat), .o_wb_ack(ack), .i_src_event(ev), .i_take_ack(take), .o_core_req(req),
    .o_core_vector(vec), .o_irq(irq));
  core_model core (.i_clk(i_clk), .i_rst(i_rst), .i_allow(allow), .i_core_req(req),
    .o_take_ack(take));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] idx, input [7:0] d, input [7:0] e);
    begin
      {cyc, stb, we, adr, wd, ev} <= {2'h3, w, idx, 2'h0, 24'h0, d, e};
      @(posedge i_clk);
      ev <= 8'h00;
      while (ack !== 1'b1) @(posedge i_clk);
      rd = dat[7:0];
      {cyc, stb} <= 2'h0;
      @(posedge i_clk);
    end
  endtask
  task rchk(input [7:0] idx, input [7:0] exp);
    begin
      bus(1'b0, idx, 8'h00, 8'h00);
      chk(rd, exp);
    end
  endtask
  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #50000;
    fails = fails + 1;
    print_verdict;
  end
  initial begin
    {cyc, stb, we, allow, adr, wd, ev} = 0;
    i_rst = 1'b1;
    fails = 0;
    cmp_count = 0;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rchk(clr, 8'h00);
    bus(1'b0, nul, 8'h00, 8'hff);
    rchk(clr, 8'hff);
    bus(1'b1, clr, 8'hff, 8'h00);
    rchk(clr, 8'hff);
    bus(1'b1, clr, 8'h5a, 8'h00);
    rchk(clr, 8'h5a);
    bus(1'b1, clr, 8'h00, 8'h09);
    rchk(clr, 8'h09);
    bus(1'b1, `IDX_VECTOR, 8'h00, 8'h00);
    rchk(clr, 8'h09);
    bus(1'b1, `IDX_GLOBAL_EN, 8'h01, 8'h00);
    chk(req, 8'h00);
    bus(1'b1, `IDX_SOURCE_MASK, 8'h09, 8'h00);
    rchk(nul, 8'h00);
    chk(vec, `VEC_BASE);
    chk(req, 8'h01);
    allow <= 1'b1;
    while (take !== 1'b1) @(posedge i_clk);
    allow <= 1'b0;
    rchk(clr, 8'h08);
    chk(vec, `VEC_BASE + 3 * `VEC_STEP);
    bus(1'b1, `IDX_GLOBAL_EN, 8'h00, 8'h00);
    rchk(`IDX_SW_CONTROL, 8'h00);
    chk(req, 8'h00);
    $display("post, mask and priority test done");
    bus(1'b1, `IDX_SW_CONTROL, 8'h01, 8'h00);
    bus(1'b1, clr, 8'h00, 8'h00);
    bus(1'b1, clr, 8'h30, 8'h00);
    rchk(clr, 8'h38);
    bus(1'b1, `IDX_IRQ_CLEAR, 8'h07, 8'h00);
    bus(1'b1, `IDX_IRQ_ENABLE, 8'h01, 8'h00);
    chk(irq, 8'h00);
    bus(1'b0, nul, 8'h00, 8'h01);
    rchk(`IDX_IRQ_STATUS, 8'h01);
    chk(irq, 8'h01);
    bus(1'b1, `IDX_IRQ_CLEAR, 8'h01, 8'h00);
    rchk(`IDX_IRQ_STATUS, 8'h00);
    chk(irq, 8'h00);
    $display("software post and interrupt test done");
    print_verdict;
  end
endmodule
